/* File: design/jmpd_map.svh */
// Purpose: constants for the link mode parameter decoder
// Assumes: 100 MHz device clock, word-wide plain register port
// Notes:   offsets are word indices on the plain port
// Summary of operation
// - one mode code derives all link parameters except frame count, scrambling and identifier
// - interleave flag one for single-channel modes
// - line rate is clock times bits-per-clock
// - bits-per-clock selects serializer multiplier or bypass
// - frame count outside mode limits flagged in status, not corrected
// - multiframe length equals programmed frame count
// - all format fields sent in alignment sequence
// - adjust, bank, control, density, reserved read zero
// - control bits per sample always reported zero
// - device identifier comes from user register
// - checksum is field sum modulo 256
// - converter count sets packing, not channels
// - derive octets, samples, resolution, padded width
// - mode 0: 4 lanes, 4 converters, R=4
// - mode 1: 8 lanes, 8 converters, R=2
// - unused higher lanes of each link powered down
// - second link identifier is register plus one
`ifndef JMPD_MAP_SVH
`define JMPD_MAP_SVH
`define JMPD_OFS_MODE     4'h0
`define JMPD_OFS_KM1      4'h1
`define JMPD_OFS_DEVID    4'h2
`define JMPD_OFS_CTRL     4'h3
`define JMPD_OFS_STATUS   4'h4
`define JMPD_OFS_PARAM    4'h5
`define JMPD_OFS_ILAS     4'h6
`define JMPD_RST_MODE     5'h00
`define JMPD_RST_KM1      5'h1F
`define JMPD_RST_DEVID    8'h00
`define JMPD_CTRL_EN_BIT  0
`define JMPD_CTRL_SCR_BIT 1
`define JMPD_K_MIN        6'h03
`define JMPD_K_MAX        6'h20
`define JMPD_JESDV        3'h1
`define JMPD_SUBCLASSV    3'h1
`endif

/* File: design/jmpd_pkg.sv */
// Purpose: types for the link mode parameter decoder
// Assumes: only mode codes 0 and 1 are implemented
// Notes:   none
package jmpd_pkg;
  typedef struct packed {
    logic       des;
    logic [4:0] decim;
    logic [1:0] links;
    logic [4:0] resN;
    logic [4:0] resNp;
    logic [4:0] lanes;
    logic [4:0] convM;
    logic [4:0] octF;
    logic [4:0] smpS;
    logic [2:0] bitsR;
    logic       valid;
  } jmpd_mode_s;
  typedef struct packed {
    logic [7:0] chk0;
    logic [7:0] chk1;
    logic [7:0] did1;
    logic [7:0] did0;
  } jmpd_ilas_s;
endpackage : jmpd_pkg

/* File: design/jmpd_decoder.sv */
// Purpose: mode code decoder building link transport and alignment fields
// Assumes: plain register port, read data one cycle after read strobe
// Notes:   per-lane identifiers are excluded from the checksum here
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "jmpd_map.svh"
module jmpd_decoder #(
  parameter int LANES_PER_LINK = 8
) (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic [3:0]                regAddr,
  input  wire logic [31:0]               regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [31:0]               regRdata,
  output logic                           linkEnable,
  output logic                           scramblerEnable,
  output logic      [2:0]                serdesBitsPerClk,
  output logic                           serdesPllBypass,
  output logic      [LANES_PER_LINK-1:0] laneEnableA,
  output logic      [LANES_PER_LINK-1:0] laneEnableB,
  output logic      [5:0]                multiframeLen,
  output jmpd_pkg::jmpd_mode_s           modeParams,
  output jmpd_pkg::jmpd_ilas_s           ilasFields
);

  logic [4:0] link_mode_select_q;
  logic [4:0] frames_per_multiframe_minus_one_q;
  logic [7:0] devId_q;
  logic       enable_q;
  logic       scr_q;
  logic       badK_q;
  jmpd_pkg::jmpd_mode_s mode_d;
  logic [7:0] chkBase;
  logic [5:0] kCount;

  function automatic jmpd_pkg::jmpd_mode_s decodeMode(input logic [4:0] code);
    jmpd_pkg::jmpd_mode_s m;
    m = '0;
    unique case (code)
      5'h00: begin
        m = '{des: 1'b1, decim: 5'h01, links: 2'h2, resN: 5'h0C, resNp: 5'h0C, lanes: 5'h04,
              convM: 5'h04, octF: 5'h08, smpS: 5'h05, bitsR: 3'h4, valid: 1'b1};
      end
      5'h01: begin
        m = '{des: 1'b1, decim: 5'h01, links: 2'h2, resN: 5'h0C, resNp: 5'h0C, lanes: 5'h08,
              convM: 5'h08, octF: 5'h08, smpS: 5'h05, bitsR: 3'h2, valid: 1'b1};
      end
      default: m = '0; // unlisted codes give no valid mode
    endcase
    return m;
  endfunction : decodeMode

  // checksum over alignment fields other than identifiers; fields sent as value-minus-one where the link defines so
  function automatic logic [7:0] ilasSum(input jmpd_pkg::jmpd_mode_s m, input logic [4:0] km1,
                                         input logic scr);
    logic [7:0] s;
    s = 8'h00;
    s = s + {3'h0, m.lanes - 5'h01};           // lanes minus one
    s = s + {7'h00, scr};
    s = s + {3'h0, m.octF - 5'h01};
    s = s + {3'h0, km1};
    s = s + {3'h0, m.convM - 5'h01};
    s = s + {3'h0, m.resN - 5'h01};
    s = s + {3'h0, m.resNp - 5'h01};
    s = s + {5'h00, `JMPD_SUBCLASSV};
    s = s + {5'h00, `JMPD_JESDV};
    s = s + {3'h0, m.smpS - 5'h01};
    // adjust, direction, bank, control words, density, control bits, reserved add zero
    return s;
  endfunction : ilasSum

  // configuration writes land only while the link is off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_mode_select_q                <= `JMPD_RST_MODE;
      frames_per_multiframe_minus_one_q <= `JMPD_RST_KM1;
      devId_q                           <= `JMPD_RST_DEVID;
    end else if (regWr && !enable_q) begin
      if (regAddr == `JMPD_OFS_MODE) begin
        link_mode_select_q <= regWdata[4:0];
      end
      if (regAddr == `JMPD_OFS_KM1) begin
        frames_per_multiframe_minus_one_q <= regWdata[4:0];
      end
      if (regAddr == `JMPD_OFS_DEVID) begin
        devId_q <= regWdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= 1'b0;
      scr_q    <= 1'b0;
    end else if (regWr && regAddr == `JMPD_OFS_CTRL) begin
      enable_q <= regWdata[`JMPD_CTRL_EN_BIT];
      if (!enable_q) begin
        scr_q <= regWdata[`JMPD_CTRL_SCR_BIT];
      end
    end
  end

  assign mode_d  = decodeMode(link_mode_select_q);
  assign kCount  = {1'b0, frames_per_multiframe_minus_one_q} + 6'h01;
  assign chkBase = ilasSum(mode_d, frames_per_multiframe_minus_one_q, scr_q);

  // out-of-range frame count flagged for software, not corrected
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      badK_q <= 1'b0;
    end else begin
      badK_q <= (kCount < `JMPD_K_MIN) || (kCount > `JMPD_K_MAX) || !mode_d.valid;
    end
  end

  // derived outputs registered; stable since inputs only move while disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modeParams       <= '0;
      serdesBitsPerClk <= 3'h0;
      serdesPllBypass  <= 1'b0;
      multiframeLen    <= 6'h00;
      ilasFields       <= '0;
      linkEnable       <= 1'b0;
      scramblerEnable  <= 1'b0;
    end else begin
      modeParams       <= mode_d;
      serdesBitsPerClk <= mode_d.bitsR;
      serdesPllBypass  <= (mode_d.bitsR == 3'h1);
      multiframeLen    <= kCount;
      ilasFields.did0  <= devId_q;
      ilasFields.did1  <= devId_q + 8'h01;
      ilasFields.chk0  <= chkBase + devId_q;
      ilasFields.chk1  <= chkBase + devId_q + 8'h01;
      linkEnable       <= enable_q && mode_d.valid;        // invalid mode never starts link
      scramblerEnable  <= scr_q;
    end
  end

  // lowest lanes used, the rest powered down
  genvar g;
  generate
    for (g = 0; g < LANES_PER_LINK; g++) begin : gLane
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          laneEnableA[g] <= 1'b0;
          laneEnableB[g] <= 1'b0;
        end else begin
          laneEnableA[g] <= enable_q && (5'(g) < mode_d.lanes);
          laneEnableB[g] <= enable_q && (mode_d.links == 2'h2) && (5'(g) < mode_d.lanes);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        `JMPD_OFS_MODE:   regRdata <= {27'h0, link_mode_select_q};
        `JMPD_OFS_KM1:    regRdata <= {27'h0, frames_per_multiframe_minus_one_q};
        `JMPD_OFS_DEVID:  regRdata <= {24'h0, devId_q};
        `JMPD_OFS_CTRL:   regRdata <= {30'h0, scr_q, enable_q};
        `JMPD_OFS_STATUS: regRdata <= {29'h0, badK_q, mode_d.valid, linkEnable};
        `JMPD_OFS_PARAM:  regRdata <= {mode_d.des, mode_d.decim, mode_d.links, mode_d.lanes,
                                       mode_d.convM, mode_d.octF, mode_d.smpS, mode_d.bitsR, 1'b0};
        `JMPD_OFS_ILAS:   regRdata <= ilasFields;
        default:          regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule : jmpd_decoder

/* File: testbench/jmpd_decoder_assertions.sv */
// Purpose: port-level checks for the link mode decoder
// Assumes: one clock, asynchronous active-low reset
// Notes:   sees only the decoder's ports
`timescale 1ns/1ps
module jmpd_decoder_assertions #(
  parameter int LANES_PER_LINK = 8
) (
  input wire logic                      clk,
  input wire logic                      arst_n,
  input wire logic [3:0]                regAddr,
  input wire logic [31:0]               regWdata,
  input wire logic                      regWr,
  input wire logic                      regRd,
  input wire logic [31:0]               regRdata,
  input wire logic                      linkEnable,
  input wire logic [2:0]                serdesBitsPerClk,
  input wire logic                      serdesPllBypass,
  input wire logic [LANES_PER_LINK-1:0] laneEnableA,
  input wire logic [LANES_PER_LINK-1:0] laneEnableB,
  input wire logic [5:0]                multiframeLen,
  input jmpd_pkg::jmpd_mode_s           modeParams,
  input jmpd_pkg::jmpd_ilas_s           ilasFields
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic enSeen_q;
  // mirrors the decoder's enable bit; linkEnable lags it and would miss dropped writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enSeen_q <= 1'b0;
    end else if (regWr && regAddr == 4'h3) begin
      enSeen_q <= regWdata[0];
    end
  end
  // enable bit shows two edges later, held off by an unlisted mode
  property p_enable;
    regWr && regAddr == 4'h3 |-> ##2 linkEnable == ($past(regWdata[0], 2) && modeParams.valid);
  endproperty
  a_read_idle: assert property (!$past(regRd) |-> regRdata == 32'h0) else $error("read data not idle");
  a_mode_zero: assert property (modeParams.valid && modeParams.lanes == 5'h04 |-> modeParams.convM == 5'h04 && modeParams.bitsR == 3'h4) else $error("mode 0 fields");
  a_mode_one: assert property (modeParams.valid && modeParams.lanes == 5'h08 |-> modeParams.convM == 5'h08 && modeParams.bitsR == 3'h2) else $error("mode 1 fields");
  a_single_chan: assert property (modeParams.valid |-> modeParams.des && modeParams.decim == 5'h01) else $error("interleave flag");
  a_serdes_sel: assert property (serdesBitsPerClk == modeParams.bitsR && serdesPllBypass == (serdesBitsPerClk == 3'h1)) else $error("serdes select");
  a_lane_fill: assert property (linkEnable |-> laneEnableA == LANES_PER_LINK'((16'h1 << modeParams.lanes) - 16'h1) && laneEnableB == laneEnableA) else $error("lane enables");
  a_lanes_off: assert property (!linkEnable |-> laneEnableA == '0 && laneEnableB == '0) else $error("lanes on while off");
  a_link_id: assert property ($past(arst_n) |-> ilasFields.did1 == ilasFields.did0 + 8'h01) else $error("second link id");
  a_chk_pair: assert property ($past(arst_n) |-> ilasFields.chk1 == ilasFields.chk0 + 8'h01) else $error("checksum pair");
  a_frame_len: assert property (regWr && regAddr == 4'h1 && !enSeen_q |-> ##2 multiframeLen == {1'b0, $past(regWdata[4:0], 2)} + 6'h01) else $error("multiframe length");
  a_enable_lag: assert property (p_enable) else $error("link enable lag");
  c_enable: cover property ($rose(linkEnable));
  c_mode_one: cover property (modeParams.lanes == 5'h08);
  c_invalid: cover property (!modeParams.valid);
endmodule : jmpd_decoder_assertions

/* File: testbench/jmpd_rx_model.sv */
// Purpose: receiving logic device, captures alignment fields
// Assumes: fields are sampled on the rise of link enable
// Notes:   no lane data; only the alignment parameters
`timescale 1ns/1ps
module jmpd_rx_model (
  input wire logic             clk,
  input wire logic             arst_n,
  input wire logic             linkEnable,
  input jmpd_pkg::jmpd_ilas_s  ilasFields,
  output jmpd_pkg::jmpd_ilas_s ilasRx_q
);
  logic enSeen_q;
  // links told apart by identifier captured at start of link
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enSeen_q <= 1'b0;
      ilasRx_q <= '0;
    end else begin
      enSeen_q <= linkEnable;
      if (linkEnable && !enSeen_q) ilasRx_q <= ilasFields;
    end
  end
endmodule : jmpd_rx_model

/* File: testbench/tb.sv */
// Purpose: register-level tests of the link mode decoder
// Assumes: settle waits cover the two-cycle enable path
// Notes:   expected values built from the mode table
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic arst_n, regWr, regRd, linkEnable, scramblerEnable, serdesPllBypass;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [2:0] serdesBitsPerClk;
  logic [7:0] laneEnableA, laneEnableB;
  logic [5:0] multiframeLen;
  jmpd_pkg::jmpd_mode_s modeParams;
  jmpd_pkg::jmpd_ilas_s ilasFields, ilasRx;
  int err_count = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  jmpd_decoder #(.LANES_PER_LINK(8)) DUT (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .linkEnable(linkEnable), .scramblerEnable(scramblerEnable),
    .serdesBitsPerClk(serdesBitsPerClk), .serdesPllBypass(serdesPllBypass), .laneEnableA(laneEnableA),
    .laneEnableB(laneEnableB), .multiframeLen(multiframeLen), .modeParams(modeParams), .ilasFields(ilasFields));
  jmpd_rx_model u_rx (.clk(clk), .arst_n(arst_n), .linkEnable(linkEnable), .ilasFields(ilasFields), .ilasRx_q(ilasRx));
  task wrap_up;
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(regRdata, exp);
  endtask : rd
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  // lane count, bits per clock, frame register, scrambler, identifier
  task link(input logic [4:0] l, input logic [2:0] r, input logic [4:0] k, input logic s, input logic [7:0] d);
    logic [7:0] c;
    c = 8'(l) - 8'h01 + 8'(s) + 8'h07 + 8'(k) + 8'(l) - 8'h01 + 8'h0B + 8'h0B + 8'h02 + 8'h04 + d;
    check(modeParams, {1'b1, 5'h01, 2'h2, 5'h0C, 5'h0C, l, l, 5'h08, 5'h05, r, 1'b1});
    check(multiframeLen, {1'b0, k} + 6'h01);
    check(ilasFields, {c, c + 8'h01, d + 8'h01, d});
    check({serdesBitsPerClk, serdesPllBypass, scramblerEnable}, {r, 1'b0, s});
  endtask : link
  initial begin
    arst_n = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWdata = 32'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    settle;
    rd(4'h0, 32'h0); rd(4'h1, 32'h1F); rd(4'h2, 32'h0); rd(4'h3, 32'h0); rd(4'hF, 32'h0);
    rd(4'h5, {1'b1, 5'h01, 2'h2, 5'h04, 5'h04, 5'h08, 5'h05, 3'h4, 1'b0});
    link(5'h04, 3'h4, 5'h1F, 1'b0, 8'h00);
    wr(4'h2, 32'h10); wr(4'h1, 32'h02); wr(4'h0, 32'h1); wr(4'h3, 32'h2);
    settle;
    link(5'h08, 3'h2, 5'h02, 1'b1, 8'h10);
    wr(4'h3, 32'h3); wr(4'h0, 32'h0); wr(4'h1, 32'h05);
    settle;
    rd(4'h0, 32'h1); rd(4'h4, 32'h3);
    link(5'h08, 3'h2, 5'h02, 1'b1, 8'h10);
    check({linkEnable, laneEnableA, laneEnableB}, {1'b1, 8'hFF, 8'hFF});
    check({ilasRx.did1, ilasRx.did0}, 16'h1110);
    wr(4'h3, 32'h0); wr(4'h0, 32'h0); wr(4'h1, 32'h01); wr(4'h2, 32'hFF);
    settle;
    rd(4'h4, 32'h6);
    wr(4'h1, 32'h1F); wr(4'h0, 32'h2);
    settle;
    check({modeParams.valid, serdesBitsPerClk}, 4'h0);
    wr(4'h3, 32'h1);
    settle;
    rd(4'h4, 32'h4);
    wr(4'h3, 32'h0); wr(4'h0, 32'h0); wr(4'h3, 32'h1);
    settle;
    link(5'h04, 3'h4, 5'h1F, 1'b0, 8'hFF);
    check({linkEnable, laneEnableA, laneEnableB}, {1'b1, 8'h0F, 8'h0F});
    wrap_up;
  end
  initial begin
    #20000;
    err_count++;
    wrap_up;
  end
endmodule : tb
bind jmpd_decoder jmpd_decoder_assertions #(.LANES_PER_LINK(LANES_PER_LINK)) u_chk (.clk(clk), .arst_n(arst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .linkEnable(linkEnable),
  .serdesBitsPerClk(serdesBitsPerClk), .serdesPllBypass(serdesPllBypass), .laneEnableA(laneEnableA),
  .laneEnableB(laneEnableB), .multiframeLen(multiframeLen), .modeParams(modeParams), .ilasFields(ilasFields));
